/* torque_off_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "torque_off_map.svh"
module torque_off_monitor #(
  parameter longint SKEW_CYCLES     = `SKEW_CYCLES,
  parameter longint SHUTDOWN_CYCLES = `SHUTDOWN_CYCLES
) (
  input  wire logic                       ref_clk,
  input  wire logic                       srst,
  input  wire logic                       clk_en,
  input  wire logic                       safe_off_channel_first,
  input  wire logic                       safe_off_channel_second,
  input  wire logic                       hw_defect,
  output var  logic                       gate_enable,
  output var  logic                       torque_off_status_output,
  output var  logic                       channel_fault,
  output var  logic                       diag_locked,
  output var  logic [`CODE_W-1:0]         error_code,
  output var  torque_off_pkg::mon_state_t state
);
  import torque_off_pkg::*;

  localparam int TW = 40;

  initial begin
    if (SKEW_CYCLES < 1 || SHUTDOWN_CYCLES < 1 || SKEW_CYCLES >= (64'd1 << TW) ||
        SHUTDOWN_CYCLES >= (64'd1 << TW)) begin
      $error("torque_off_monitor: timing parameter out of range");
    end
  end

  localparam logic [TW-1:0] SKEW_LIM = SKEW_CYCLES[TW-1:0];
  localparam logic [TW-1:0] SHUT_LIM = SHUTDOWN_CYCLES[TW-1:0];

  skew_timer_if #(.W(TW)) tmr ();

  skew_timer #(.W(TW)) u_timer (
    .ref_clk (ref_clk),
    .srst    (srst),
    .clk_en  (clk_en),
    .tmr     (tmr.timer)
  );

  logic                both_on;
  logic                both_off;
  logic                differ;
  mon_state_t          next_state;
  logic                next_gate_enable;
  logic                next_status;
  logic                next_channel_fault;
  logic                next_diag_locked;
  logic [`CODE_W-1:0]  next_error_code;

  assign both_on  = safe_off_channel_first & safe_off_channel_second;
  assign both_off = ~safe_off_channel_first & ~safe_off_channel_second;
  assign differ   = safe_off_channel_first ^ safe_off_channel_second;

  always_comb begin
    next_state  = state;
    tmr.restart = 1'b0;
    tmr.run     = 1'b0;
    next_channel_fault = channel_fault;
    next_diag_locked   = diag_locked;
    next_error_code    = error_code;
    case (state)
      st_off, st_run: begin
        tmr.restart = 1'b1;
        if (hw_defect) begin
          next_state       = st_locked;  // see [R3]
          next_diag_locked = 1'b1;
          next_error_code  = `CODE_DIAG;
        end else if (differ) begin
          next_state = st_skew;
        end else if (both_on) begin
          next_state = st_run;  // see [R13]
        end else begin
          next_state = st_off;  // see [R2]
        end
      end
      st_skew: begin
        tmr.run = 1'b1;
        if (hw_defect) begin
          next_state       = st_locked;
          next_diag_locked = 1'b1;
          next_error_code  = `CODE_DIAG;
        end else if (!differ) begin
          tmr.restart = 1'b1;  // see [R15]
          next_state  = both_on ? st_run : st_off;
        end else if (tmr.count >= SKEW_LIM - 1) begin  // see [R9]
          tmr.restart        = 1'b1;
          next_state         = st_fault;  // see [R10]
          next_channel_fault = 1'b1;
          next_error_code    = `CODE_CH_FAULT;
        end
      end
      st_fault: begin
        tmr.run = 1'b1;
        if (hw_defect || (differ && tmr.count >= SHUT_LIM - 1)) begin
          next_state       = st_locked;  // see [R12] see [R4]
          next_diag_locked = 1'b1;
          next_error_code  = `CODE_DIAG;
        end else if (!differ) begin
          tmr.restart        = 1'b1;  // see [R15]
          next_channel_fault = 1'b0;
          next_error_code    = `CODE_NONE;
          next_state         = both_on ? st_run : st_off;
        end
      end
      st_locked: begin
        next_state = st_locked;  // see [R5]
      end
      default: begin
        next_state = st_locked;
      end
    endcase
    // Either channel low alone drops gate drive; no braking, drive coasts
    next_gate_enable = both_on && (next_state == st_run || next_state == st_skew ||
                                   next_state == st_fault) && !next_diag_locked;  // see [R1] see [R7] see [R14]
    next_status      = ~next_gate_enable;  // see [R6]
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state                    <= st_off;
      gate_enable              <= 1'b0;
      torque_off_status_output <= 1'b1;
      channel_fault            <= 1'b0;
      diag_locked              <= 1'b0;
      error_code               <= `CODE_NONE;
    end else if (clk_en) begin
      state                    <= next_state;
      gate_enable              <= next_gate_enable;
      torque_off_status_output <= next_status;
      channel_fault            <= next_channel_fault;
      diag_locked              <= next_diag_locked;
      error_code               <= next_error_code;
    end
  end

  // Assertions
  a_gate_needs_both: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && !both_on |=> !gate_enable) else $error("gate on without both channels"); // see [R1]
  a_both_off_blocks: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && both_off |=> !gate_enable && torque_off_status_output)
    else $error("both off did not block"); // see [R2]
  a_lock_holds: assert property (@(posedge ref_clk) disable iff (srst)
    diag_locked |=> diag_locked && !gate_enable && error_code == `CODE_DIAG)
    else $error("lock released"); // see [R5]
  a_status_tracks: assert property (@(posedge ref_clk) disable iff (srst)
    torque_off_status_output == !gate_enable) else $error("status mismatch"); // see [R6]
  a_defect_locks: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && hw_defect |=> diag_locked) else $error("defect not locked"); // see [R3]
  a_fault_first: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(diag_locked) && !$past(hw_defect) |-> $past(channel_fault))
    else $error("shutdown without prior fault"); // see [R10]
  a_skew_quiet: assert property (@(posedge ref_clk) disable iff (srst)
    state == st_skew && tmr.count < SKEW_LIM - 1 |=> !channel_fault)
    else $error("fault inside tolerance"); // see [R9]
  a_shutdown_time: assert property (@(posedge ref_clk) disable iff (srst)
    state == st_fault && differ && clk_en && tmr.count >= SHUT_LIM - 1 |=> diag_locked)
    else $error("shutdown late"); // see [R12]
  a_resume_auto: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && state == st_off && both_on && !hw_defect |=> gate_enable)
    else $error("no automatic resume"); // see [R13]
  a_timer_restart: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && state == st_run |=> tmr.count == '0) else $error("timer not restarted"); // see [R15]

  c_run: cover property (@(posedge ref_clk) disable iff (srst) $rose(gate_enable));
  c_fault: cover property (@(posedge ref_clk) disable iff (srst) $rose(channel_fault));
  c_lock: cover property (@(posedge ref_clk) disable iff (srst) $rose(diag_locked));
  c_recover: cover property (@(posedge ref_clk) disable iff (srst) $fell(channel_fault));
endmodule
`default_nettype wire

/* torque_off_map.svh */
// Operation
// [R1] Gate drive enabled only while both safety channels are active.
// [R2] Both channels inactive puts the block in torque-off, gate drive blocked.
// [R3] Diagnostics compare channels; mismatch or internal defect commands switch-off.
// [R4] Channel disagreement ends in safe turn-off within 1600 ms.
// [R5] Diagnostic error latches; only a supply cycle clears it.
// [R6] A status output reflects the torque-off function state.
// [R7] Either channel inactive alone switches the output stage off.
// [R8] Controller switches both channels together on every journey.
// [R9] Skew up to 120 ms between channels raises no fault.
// [R10] Skew beyond the limit first raises channel fault code 533.
// [R11] Controller may abort travel on seeing the channel fault.
// [R12] Persisting mismatch gives diagnostic shutdown 960 within 190 to 1480 ms.
// [R13] Drive resumes automatically once both channels return; no confirmation.
// [R14] Torque-off applies no active braking; the drive coasts.
// [R15] Intervals timed by an internal counter that restarts on channel agreement.
`ifndef TORQUE_OFF_MAP_SVH
`define TORQUE_OFF_MAP_SVH
`define CLK_PERIOD_PS    5000
`define SKEW_LIMIT_MS    120
`define SHUTDOWN_WAIT_MS 630
`define SKEW_CYCLES      (`SKEW_LIMIT_MS * 64'd1000000000 / `CLK_PERIOD_PS)
`define SHUTDOWN_CYCLES  (`SHUTDOWN_WAIT_MS * 64'd1000000000 / `CLK_PERIOD_PS)
`define CODE_NONE        12'h000
`define CODE_CH_FAULT    12'h215
`define CODE_DIAG        12'h3c0
`define CODE_W           12
`endif

/* torque_off_pkg.sv */
package torque_off_pkg;
  typedef enum logic [2:0] {
    st_off,
    st_run,
    st_skew,
    st_fault,
    st_locked
  } mon_state_t;
endpackage

/* skew_timer_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface skew_timer_if #(parameter int W = 40);
  logic         restart;
  logic         run;
  logic [W-1:0] count;
  modport owner (output restart, output run, input count);
  modport timer (input restart, input run, output count);
endinterface
`default_nettype wire

/* skew_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module skew_timer #(
  parameter int W = 40
) (
  input wire logic     ref_clk,
  input wire logic     srst,
  input wire logic     clk_en,
  skew_timer_if.timer  tmr
);
  logic [W-1:0] next_count;

  always_comb begin
    next_count = tmr.count;
    if (tmr.restart) begin  // see [R15]
      next_count = '0;
    end else if (tmr.run && tmr.count != {W{1'b1}}) begin
      next_count = tmr.count + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tmr.count <= '0;
    end else if (clk_en) begin
      tmr.count <= next_count;
    end
  end
endmodule
`default_nettype wire

/* relay_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module relay_ctrl (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       travel,
  input  wire logic [4:0] lag,
  input  wire logic       stuck,
  output var  logic       ch_first,
  output var  logic       ch_second
);
  logic [4:0] cnt;
  // Stuck models a welded contact: second relay keeps its last level
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ch_first  <= 1'b0;
      ch_second <= 1'b0;
      cnt       <= 5'h00;
    end else begin
      ch_first <= travel;
      if (stuck || ch_second == travel) begin
        cnt <= 5'h00;
      end else if (cnt >= lag) begin
        ch_second <= travel;
        cnt       <= 5'h00;
      end else begin
        cnt <= cnt + 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam longint SKEW = 20;
  localparam longint SHUT = 30;
  logic ref_clk = 1'b0, srst = 1'b1, clk_en = 1'b1, hw_defect = 1'b0;
  logic travel = 1'b0, stuck = 1'b0;
  logic [4:0] lag = 5'h00;
  logic a, b, gate, status, fault, locked;
  logic [11:0] code;
  torque_off_pkg::mon_state_t state;
  int miscompares = 0, check_count = 0, seed = 2382, n;
  always #2.5 ref_clk = ~ref_clk;
  relay_ctrl relay_ctrl_inst (.ref_clk(ref_clk), .srst(srst), .travel(travel),
    .lag(lag), .stuck(stuck), .ch_first(a), .ch_second(b));
  torque_off_monitor #(.SKEW_CYCLES(SKEW), .SHUTDOWN_CYCLES(SHUT)) torque_off_monitor_inst (
    .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .safe_off_channel_first(a),
    .safe_off_channel_second(b), .hw_defect(hw_defect), .gate_enable(gate),
    .torque_off_status_output(status), .channel_fault(fault), .diag_locked(locked),
    .error_code(code), .state(state));
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Gate already on three edges after a rising request only when the second channel lags under 2 edges
  function automatic logic mid_gate(input logic tr, input logic [4:0] lg);
    return tr && lg < 5'h02;
  endfunction
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #15000;
    miscompares++;
    stop_test();
  end
  initial begin
    cyc(12);
    srst = 1'b0;
    chk({gate, status, fault, locked}, 4'b0100);
    chk(code, 12'h000);
    chk(state, torque_off_pkg::st_off);
    for (int i = 0; i < 24; i++) begin
      lag = 5'($unsigned($random(seed)) % 16);
      travel = ~travel;
      cyc(3);
      chk(gate, mid_gate(travel, lag));
      cyc(int'(lag) + 2);
      chk({gate, status, fault}, {travel, ~travel, 1'b0});
    end
    clk_en = 1'b0;
    travel = 1'b1;
    lag = 5'h00;
    cyc(4);
    chk(gate, 1'b0);
    clk_en = 1'b1;
    cyc(3);
    chk(gate, 1'b1);
    stuck = 1'b1;
    travel = 1'b0;
    cyc(int'(SKEW) - 3);
    chk({fault, gate}, 2'b00);
    n = 0;
    while (fault !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    chk({fault, locked}, 2'b10);
    chk(code, 12'h215);
    // Controller aborts the journey on the early warning
    stuck = 1'b0;
    cyc(3);
    chk({fault, code}, 13'h0000);
    travel = 1'b1;
    cyc(4);
    chk(gate, 1'b1);
    stuck = 1'b1;
    travel = 1'b0;
    n = 0;
    while (locked !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    chk(16'(n >= SKEW + SHUT - 4), 16'h0001);
    chk({locked, gate, status}, 3'b101);
    chk(code, 12'h3c0);
    stuck = 1'b0;
    travel = 1'b1;
    cyc(10);
    chk({locked, gate}, 2'b10);
    srst = 1'b1;
    cyc(2);
    srst = 1'b0;
    chk(locked, 1'b0);
    hw_defect = 1'b1;
    cyc(1);
    hw_defect = 1'b0;
    cyc(3);
    chk({locked, gate}, 2'b10);
    stop_test();
  end
endmodule
`default_nettype wire
